// File: common/hppc_pkg.sv
package hppc_pkg;
  // ==========================================
  // Widths
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int EVT_W = 8;
  localparam int REG_N = 16;
  // ==========================================
  // Register offsets
  localparam logic [9:0] OFS_GMASK = 10'h000;
  localparam logic [9:0] OFS_FMASK = 10'h001;
  localparam logic [9:0] OFS_LMASK = 10'h002;
  localparam logic [9:0] OFS_BMASK = 10'h003;
  localparam logic [9:0] OFS_FSTAT = 10'h004;
  localparam logic [9:0] OFS_LSTAT = 10'h005;
  localparam logic [9:0] OFS_BSTAT = 10'h006;
  localparam logic [9:0] OFS_GSTAT = 10'h007;
  localparam logic [9:0] OFS_SCR0 = 10'h008;
  // ==========================================
  // Fields and reset values
  localparam int GEN_BIT = 0;
  localparam int GRP_LSB = 1;
  localparam int GRP_MSB = 3;
  localparam logic [7:0] REG_RST = 8'h00;
  // ==========================================
  // Serial frame
  localparam logic [4:0] SPI_CTRL_LAST = 5'h0f;
  localparam logic [4:0] SPI_DATA_LAST = 5'h07;
  localparam int SPI_ADDR_LSB = 1;
  typedef enum logic [1:0] {
    SP_CTRL = 2'b00,
    SP_DATA = 2'b01,
    SP_DONE = 2'b10
  } hppc_spi_st_t;
endpackage

// File: common/hppc_grp_if.sv
`timescale 1ns/100ps
interface hppc_grp_if #(parameter int W = 8);
  logic [W-1:0] evt;
  logic [W-1:0] mask;
  logic [W-1:0] clr;
  logic [W-1:0] status;
  logic pend;
  modport host (output evt, mask, clr, input status, pend);
  modport grp (input evt, mask, clr, output status, pend);
endinterface

// File: verilog/hppc_irq_grp.sv
`timescale 1ns/100ps
module hppc_irq_grp #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Source group
  hppc_grp_if.grp g
);
  logic [W-1:0] status_r;
  logic [W-1:0] status_nxt;
  logic pend_r;
  logic pend_nxt;

  // ==========================================
  // Sticky status, an event beats a clear
  always_comb begin
    status_nxt = (status_r & ~g.clr) | g.evt;
    pend_nxt = |(status_nxt & g.mask);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      status_r <= '0;
      pend_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      pend_r <= pend_nxt;
    end
  end

  assign g.status = status_r;
  assign g.pend = pend_r;

  // ==========================================
  // Checks
  a_evt_sticky: assert property (@(posedge i_clk) disable iff (i_rst)
    |g.evt |=> ((g.status & $past(g.evt)) == $past(g.evt)))
    else $error("event lost in status");
  a_clr_only: assert property (@(posedge i_clk) disable iff (i_rst)
    1'b1 |=> ((~g.status & $past(g.status) & ~$past(g.clr)) == '0))
    else $error("status dropped without clear");
endmodule // hppc_irq_grp

// File: verilog/hppc_port.sv
`timescale 1ns/100ps
// What this block does
// - A rising write strobe (data strobe when strapped high) with chip select low writes the data bus into the addressed register.
// - The interrupt pin is pulled low while any unmasked event is pending.
// - The interrupt pin is released once no unmasked event is pending, whether by host clear or by a mask write.
// - Events pass global, framer, line and bit-error mask levels before reaching the pin.
// - Bus timing strap high means direction plus data strobe, low means separate strobes.
// - The two strobe pins are read as read/write strobes or data strobe/direction per strap.
// - The active-low device reset clears all logic and registers.
// - Strobes are ignored while chip select is high.
// - A read drives the addressed register on the data bus while read strobe and select are low.
// - In serial mode data bit 2 is the serial clock, bit 1 data in and bit 0 data out.
module hppc_port
  import hppc_pkg::*;
(
  // Clock and resets
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_device_reset_n,
  // Straps
  input wire logic i_spi_sel,
  input wire logic i_bus_timing_select,
  // Processor port
  input wire logic i_chip_select_n,
  input wire logic i_read_strobe_n,
  input wire logic i_write_strobe_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_data,
  output logic [DATA_W-1:0] o_data,
  output logic [DATA_W-1:0] o_data_oe,
  // Interrupt pin, open drain
  output logic o_irq_out_n,
  output logic o_irq_oe,
  // Event sources, one-cycle pulses
  input wire logic [EVT_W-1:0] i_framer_evt,
  input wire logic [EVT_W-1:0] i_liu_evt,
  input wire logic [EVT_W-1:0] i_bert_evt,
  // Write notice to the rest of the device
  output logic o_wr_stb,
  output logic [ADDR_W-1:0] o_wr_addr,
  output logic [DATA_W-1:0] o_wr_data
);
  logic rst;
  assign rst = i_sys_rst | ~i_device_reset_n;

  hppc_grp_if #(.W(EVT_W)) fg ();
  hppc_grp_if #(.W(EVT_W)) lg ();
  hppc_grp_if #(.W(EVT_W)) bg ();

  logic [DATA_W-1:0] regs_r [REG_N];
  logic [DATA_W-1:0] regs_nxt [REG_N];

  function automatic logic [DATA_W-1:0] rd_val(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] v;
    v = '0;
    if (a == OFS_FSTAT) v = fg.status;
    else if (a == OFS_LSTAT) v = lg.status;
    else if (a == OFS_BSTAT) v = bg.status;
    else if (a == OFS_GSTAT) v = {5'h00, bg.pend, lg.pend, fg.pend};
    else if (a < ADDR_W'(REG_N)) v = regs_r[a[3:0]];
    return v;
  endfunction

  // ==========================================
  // Parallel strobes
  // Strobe pins are sampled, so the value held in the last low cycle is
  // what lands; setup time is one clock before the rising edge.
  logic wact;
  logic wq;
  logic rd_act;
  logic pfire;
  logic wq_r;
  logic wq_nxt;
  logic [ADDR_W-1:0] pa_r;
  logic [ADDR_W-1:0] pa_nxt;
  logic [DATA_W-1:0] pd_r;
  logic [DATA_W-1:0] pd_nxt;

  always_comb begin
    wact = i_bus_timing_select ? (~i_read_strobe_n & ~i_write_strobe_n)
                               : ~i_write_strobe_n;
    wq = wact & ~i_chip_select_n & ~i_spi_sel;
    rd_act = ~i_chip_select_n & ~i_spi_sel &
             (i_bus_timing_select ? (~i_read_strobe_n & i_write_strobe_n)
                                  : ~i_read_strobe_n);
    pfire = wq_r & (i_bus_timing_select ? i_read_strobe_n
                                        : i_write_strobe_n);
    wq_nxt = wq;
    pa_nxt = wq ? i_addr : pa_r;
    pd_nxt = wq ? i_data : pd_r;
  end

  always_ff @(posedge i_clk) begin
    if (rst) begin
      wq_r <= 1'b0;
      pa_r <= '0;
      pd_r <= '0;
    end else begin
      wq_r <= wq_nxt;
      pa_r <= pa_nxt;
      pd_r <= pd_nxt;
    end
  end

  // ==========================================
  // Serial port on shared data pins
  // Clock idles low, data in on rising; first read bit out on the last control rising edge, the rest on falling. Burst is ignored.
  logic sp_on;
  logic s_rise;
  logic s_fall;
  logic sfire;
  logic sclk_r;
  logic miso_r;
  logic miso_nxt;
  logic sp_rd_r;
  logic sp_rd_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic [15:0] sh_r;
  logic [15:0] sh_nxt;
  logic [DATA_W-1:0] tx_r;
  logic [DATA_W-1:0] tx_nxt;
  logic [ADDR_W-1:0] sp_a_r;
  logic [ADDR_W-1:0] sp_a_nxt;
  hppc_spi_st_t sp_st_r;
  hppc_spi_st_t sp_st_nxt;

  always_comb begin
    sp_on = i_spi_sel & ~i_chip_select_n;
    s_rise = sp_on & i_data[2] & ~sclk_r;
    s_fall = sp_on & ~i_data[2] & sclk_r;
    sfire = 1'b0;
    sp_st_nxt = sp_st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    tx_nxt = tx_r;
    miso_nxt = miso_r;
    sp_a_nxt = sp_a_r;
    sp_rd_nxt = sp_rd_r;
    if (!sp_on) begin
      sp_st_nxt = SP_CTRL;
      cnt_nxt = '0;
    end else begin
      unique case (sp_st_r)
        SP_CTRL: begin
          if (s_rise) begin
            sh_nxt = {sh_r[14:0], i_data[1]};
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == SPI_CTRL_LAST) begin
              sp_st_nxt = SP_DATA;
              cnt_nxt = '0;
              sp_rd_nxt = sh_r[14];
              sp_a_nxt = sh_nxt[SPI_ADDR_LSB +: ADDR_W];
              tx_nxt = rd_val(sh_nxt[SPI_ADDR_LSB +: ADDR_W]);
              miso_nxt = tx_nxt[DATA_W-1];
            end
          end
        end
        SP_DATA: begin
          if (s_rise) begin
            sh_nxt = {sh_r[14:0], i_data[1]};
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == SPI_DATA_LAST) begin
              sp_st_nxt = SP_DONE;
              sfire = ~sp_rd_r;
            end
          end else if (s_fall && sp_rd_r && cnt_r != '0) begin
            tx_nxt = {tx_r[DATA_W-2:0], 1'b0};
            miso_nxt = tx_r[DATA_W-2];
          end
        end
        SP_DONE: begin
          sp_st_nxt = SP_DONE;
        end
        default: begin
          sp_st_nxt = SP_CTRL;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst) begin
      sclk_r <= 1'b0;
      sp_st_r <= SP_CTRL;
      cnt_r <= '0;
      sh_r <= '0;
      tx_r <= '0;
      miso_r <= 1'b0;
      sp_a_r <= '0;
      sp_rd_r <= 1'b0;
    end else begin
      sclk_r <= i_data[2];
      sp_st_r <= sp_st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      tx_r <= tx_nxt;
      miso_r <= miso_nxt;
      sp_a_r <= sp_a_nxt;
      sp_rd_r <= sp_rd_nxt;
    end
  end

  // ==========================================
  // Register file and interrupt gating
  logic wr_fire;
  logic [ADDR_W-1:0] wr_a;
  logic [DATA_W-1:0] wr_d;
  logic [DATA_W-1:0] rd_now;
  logic irq_nxt;
  logic [DATA_W-1:0] dout_nxt;
  logic [DATA_W-1:0] doe_nxt;
  logic wr_stb_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [DATA_W-1:0] wr_data_r;
  logic [DATA_W-1:0] dout_r;
  logic [DATA_W-1:0] doe_r;
  logic irq_r;

  always_comb begin
    wr_fire = pfire | sfire;
    wr_a = pfire ? pa_r : sp_a_r;
    wr_d = pfire ? pd_r : {sh_r[6:0], i_data[1]};
    regs_nxt = regs_r;
    if (wr_fire && wr_a < ADDR_W'(REG_N) && wr_a != OFS_FSTAT &&
        wr_a != OFS_LSTAT && wr_a != OFS_BSTAT && wr_a != OFS_GSTAT)
      regs_nxt[wr_a[3:0]] = wr_d;
    fg.clr = (wr_fire && wr_a == OFS_FSTAT) ? wr_d : '0;
    lg.clr = (wr_fire && wr_a == OFS_LSTAT) ? wr_d : '0;
    bg.clr = (wr_fire && wr_a == OFS_BSTAT) ? wr_d : '0;
    fg.mask = regs_r[OFS_FMASK[3:0]];
    lg.mask = regs_r[OFS_LMASK[3:0]];
    bg.mask = regs_r[OFS_BMASK[3:0]];
    fg.evt = i_framer_evt;
    lg.evt = i_liu_evt;
    bg.evt = i_bert_evt;
    irq_nxt = regs_r[OFS_GMASK[3:0]][GEN_BIT] &
              |({bg.pend, lg.pend, fg.pend} &
                regs_r[OFS_GMASK[3:0]][GRP_MSB:GRP_LSB]);
    rd_now = rd_val(i_addr);
    dout_nxt = rd_act ? rd_now : {7'h00, miso_r};
    doe_nxt = rd_act ? 8'hff : (sp_on ? 8'h01 : 8'h00);
  end

  always_ff @(posedge i_clk) begin
    if (rst) begin
      for (int i = 0; i < REG_N; i++) regs_r[i] <= REG_RST;
      irq_r <= 1'b0;
      dout_r <= '0;
      doe_r <= '0;
      wr_stb_r <= 1'b0;
      wr_addr_r <= '0;
      wr_data_r <= '0;
    end else begin
      regs_r <= regs_nxt;
      irq_r <= irq_nxt;
      dout_r <= dout_nxt;
      doe_r <= doe_nxt;
      wr_stb_r <= wr_fire;
      wr_addr_r <= wr_a;
      wr_data_r <= wr_d;
    end
  end

  hppc_irq_grp #(.W(EVT_W)) u_fgrp (.i_clk(i_clk), .i_rst(rst), .g(fg));
  hppc_irq_grp #(.W(EVT_W)) u_lgrp (.i_clk(i_clk), .i_rst(rst), .g(lg));
  hppc_irq_grp #(.W(EVT_W)) u_bgrp (.i_clk(i_clk), .i_rst(rst), .g(bg));

  assign o_data = dout_r;
  assign o_data_oe = doe_r;
  // Pin level is a constant low; only the enable moves
  assign o_irq_out_n = 1'b0;
  assign o_irq_oe = irq_r;
  assign o_wr_stb = wr_stb_r;
  assign o_wr_addr = wr_addr_r;
  assign o_wr_data = wr_data_r;

  // ==========================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (rst);

  sequence s_wr_scr;
    pfire && pa_r == OFS_SCR0;
  endsequence

  a_par_write: assert property (s_wr_scr |=>
    regs_r[OFS_SCR0[3:0]] == $past(pd_r)) else $error("write not stored");
  a_one_write: assert property (pfire |=> !pfire)
    else $error("two writes for one strobe");
  a_cs_gate: assert property ($past(i_chip_select_n) |-> !pfire)
    else $error("write with select high");
  a_irq_low: assert property (irq_nxt |=> o_irq_oe)
    else $error("unmasked event not signalled");
  a_irq_gmask: assert property (
    !regs_r[OFS_GMASK[3:0]][GEN_BIT] |=> !o_irq_oe)
    else $error("global mask ignored");
  a_rd_drive: assert property (rd_act |=>
    o_data_oe == 8'hff && o_data == $past(rd_now)) else $error("read drive");
  a_mot_wr: assert property (i_bus_timing_select && wact |=>
    o_data_oe != 8'hff) else $error("drove bus during write");
  a_spi_pin: assert property (sp_on |=> o_data_oe == 8'h01)
    else $error("serial output enable wrong");
  a_reset_all: assert property (disable iff (1'b0) rst |=>
    !o_irq_oe && o_data_oe == 8'h00 && !o_wr_stb)
    else $error("reset did not clear");
endmodule // hppc_port

// File: sim/hppc_host.sv
`timescale 1ns/100ps
// ==========================================
// Host processor model on the port pins
module hppc_host (
  // Clock
  input wire logic i_clk,
  // Read return
  input wire logic [7:0] i_rdata,
  input wire logic [7:0] i_roe,
  // Bus pins and straps
  output logic o_cs_n,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic o_spi_sel,
  output logic o_bts,
  output logic [9:0] o_addr,
  output logic [7:0] o_data
);
  initial begin
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_spi_sel = 1'b0;
    o_bts = 1'b0;
    o_addr = 10'h000;
    o_data = 8'h00;
  end
  task automatic strap(input logic b, input logic s);
    @(posedge i_clk);
    o_bts <= b;
    o_spi_sel <= s;
  endtask
  // Strap 1 raises the data strobe before direction, else no write
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic cs);
    @(posedge i_clk);
    o_cs_n <= ~cs;
    o_addr <= a;
    o_data <= d;
    o_wr_n <= 1'b0;
    o_rd_n <= ~o_bts;
    @(posedge i_clk);
    o_rd_n <= 1'b1;
    o_wr_n <= ~o_bts;
    @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_wr_n <= 1'b1;
    o_data <= ~d; // Released bus must not keep the last value
  endtask
  task automatic rd(input logic [9:0] a, input logic cs, output logic [7:0] q,
                    output logic [7:0] oe);
    @(posedge i_clk);
    o_cs_n <= ~cs;
    o_addr <= a;
    o_rd_n <= 1'b0;
    o_wr_n <= 1'b1;
    @(posedge i_clk);
    #1;
    q = i_rdata;
    oe = i_roe;
    @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_rd_n <= 1'b1;
  endtask
  // Serial clock idles low, each phase two system cycles; the returned
  // byte holds the last eight bits seen on the serial output
  task automatic spi_xfer(input logic rw, input logic [9:0] a,
                          input logic [7:0] d, output logic [7:0] q);
    logic [23:0] f;
    f = {rw, 4'h0, a, 1'b0, d};
    q = 8'h00;
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    o_data <= 8'h00;
    for (int i = 23; i >= 0; i--) begin
      @(posedge i_clk);
      o_data[1] <= f[i];
      @(posedge i_clk);
      o_data[2] <= 1'b1;
      @(posedge i_clk);
      #1;
      q = {q[6:0], i_rdata[0]};
      @(posedge i_clk);
      o_data[2] <= 1'b0;
    end
    repeat (2) @(posedge i_clk);
    o_cs_n <= 1'b1;
  endtask
endmodule // hppc_host

// File: sim/hppc_port_bench.sv
`timescale 1ns/100ps
module hppc_port_bench;
  import hppc_pkg::*;
  logic clk, sys_rst, dev_rst_n, cs_n, rd_n, wr_n, spi_sel, bus_timing_select;
  logic irq_oe, wr_stb, irq_n;
  logic [ADDR_W-1:0] wa, wa_seen;
  logic [DATA_W-1:0] wd, wd_seen;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] din, dout, doe, q, oe;
  logic [EVT_W-1:0] fevt, levt, bevt;
  int err_count = 0;
  int cmp_count = 0;
  int wr_seen = 0;
  int cyc = 0;
  hppc_port hppc_port_inst (.i_clk(clk), .i_sys_rst(sys_rst),
    .i_device_reset_n(dev_rst_n), .i_spi_sel(spi_sel),
    .i_bus_timing_select(bus_timing_select), .i_chip_select_n(cs_n),
    .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n), .i_addr(addr),
    .i_data(din), .o_data(dout), .o_data_oe(doe), .o_irq_out_n(irq_n),
    .o_irq_oe(irq_oe), .i_framer_evt(fevt), .i_liu_evt(levt),
    .i_bert_evt(bevt), .o_wr_stb(wr_stb), .o_wr_addr(wa), .o_wr_data(wd));
  hppc_host hppc_host_inst (.i_clk(clk), .i_rdata(dout), .i_roe(doe),
    .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_spi_sel(spi_sel),
    .o_bts(bus_timing_select), .o_addr(addr), .o_data(din));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wr_stb === 1'b1) begin
      wr_seen <= wr_seen + 1;
      wa_seen <= wa;
      wd_seen <= wd;
    end
  end
  // Whole run needs well under 2000 cycles
  initial begin
    wait (cyc == 6000);
    err_count++;
    close_out();
  end
  // ==========================================
  // Checking
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic pulse(input logic [7:0] v);
    @(posedge clk);
    fevt <= v;
    levt <= v;
    bevt <= v;
    @(posedge clk);
    fevt <= 8'h00;
    levt <= 8'h00;
    bevt <= 8'h00;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    #1;
    chk("irq_rst", {7'h00, irq_oe}, 8'h00);
    chk("oe_rst", doe, 8'h00);
    chk("stb_rst", {7'h00, wr_stb}, 8'h00);
    hppc_host_inst.rd(OFS_SCR0, 1'b1, q, oe);
    chk("scr_rst", q, 8'h00);
    hppc_host_inst.rd(10'h3ff, 1'b1, q, oe);
    chk("unmapped", q, 8'h00);
  endtask
  task automatic t_rw(input logic b);
    int n;
    logic [7:0] d;
    d = 8'h5a ^ {8{b}};
    hppc_host_inst.strap(b, 1'b0);
    n = wr_seen;
    hppc_host_inst.wr(OFS_SCR0 + 10'(b), d, 1'b1);
    hppc_host_inst.rd(OFS_SCR0 + 10'(b), 1'b1, q, oe);
    chk("rd_data", q, d);
    chk("rd_oe", oe, 8'hff);
    chk("one_write", 8'(wr_seen - n), 8'h01);
    chk("wr_data", wd_seen, d);
    chk("wr_addr", 8'(wa_seen), 8'(OFS_SCR0) + 8'(b));
    hppc_host_inst.wr(OFS_SCR0 + 10'(b), 8'h00, 1'b0);
    hppc_host_inst.rd(OFS_SCR0 + 10'(b), 1'b1, q, oe);
    chk("cs_high_wr", q, d);
    hppc_host_inst.rd(OFS_SCR0 + 10'(b), 1'b0, q, oe);
    chk("cs_high_oe", oe, 8'h00);
  endtask
  task automatic t_irq();
    hppc_host_inst.strap(1'b0, 1'b0);
    hppc_host_inst.wr(OFS_GMASK, 8'h03, 1'b1);
    hppc_host_inst.wr(OFS_FMASK, 8'h01, 1'b1);
    hppc_host_inst.wr(OFS_BMASK, 8'hff, 1'b1);
    pulse(8'h01);
    repeat (3) @(posedge clk);
    #1 chk("irq_set", {7'h00, irq_oe}, 8'h01);
    chk("irq_pin", {7'h00, irq_n}, 8'h00);
    hppc_host_inst.rd(OFS_LSTAT, 1'b1, q, oe);
    chk("masked_stat", q, 8'h01);
    hppc_host_inst.wr(OFS_FSTAT, 8'h01, 1'b1);
    repeat (3) @(posedge clk);
    #1 chk("irq_clear", {7'h00, irq_oe}, 8'h00);
    hppc_host_inst.wr(OFS_GMASK, 8'h09, 1'b1);
    repeat (3) @(posedge clk);
    #1 chk("grp_enable", {7'h00, irq_oe}, 8'h01);
    hppc_host_inst.wr(OFS_GMASK, 8'h08, 1'b1);
    repeat (3) @(posedge clk);
    #1 chk("global_off", {7'h00, irq_oe}, 8'h00);
  endtask
  task automatic t_dev_rst();
    hppc_host_inst.wr(OFS_SCR0, 8'h3c, 1'b1);
    @(posedge clk);
    dev_rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    dev_rst_n <= 1'b1;
    hppc_host_inst.rd(OFS_SCR0, 1'b1, q, oe);
    chk("pin_reset", q, 8'h00);
  endtask
  task automatic t_spi();
    int n;
    hppc_host_inst.strap(1'b0, 1'b1);
    n = wr_seen;
    hppc_host_inst.spi_xfer(1'b0, 10'h00a, 8'hc3, q);
    hppc_host_inst.spi_xfer(1'b1, 10'h00a, 8'h00, q);
    chk("spi_read", q, 8'hc3);
    chk("spi_wr_addr", 8'(wa_seen), 8'h0a);
    chk("spi_wr_data", wd_seen, 8'hc3);
    hppc_host_inst.strap(1'b0, 1'b0);
    hppc_host_inst.rd(10'h00a, 1'b1, q, oe);
    chk("spi_write", q, 8'hc3);
    chk("spi_once", 8'(wr_seen - n), 8'h01);
  endtask
  initial begin
    sys_rst = 1'b1;
    dev_rst_n = 1'b1;
    fevt = 8'h00;
    levt = 8'h00;
    bevt = 8'h00;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_rw(1'b0);
    t_rw(1'b1);
    t_irq();
    t_dev_rst();
    t_spi();
    close_out();
  end
endmodule // hppc_port_bench
